// ==== hdl/uim_channel.sv ====
// Purpose: Interrupt ranking, enables and modem control of one channel
// Assumes: Rx/Tx data paths and line status logic share CLK_I
// Notes: Modem pins and serial input are synchronised before use
//
// Design decisions made here: strobed register access and the address map.
`timescale 1ns/1ps
module uim_channel #(
   parameter int TO_CNT_W = 12
) (
   input wire logic CLK_I,
   input wire logic SYS_RST_I,
   input wire logic [2:0] ADDR_I,
   input wire logic [7:0] WDATA_I,
   input wire logic WR_I,
   input wire logic RD_I,
   output logic [7:0] RDATA_O,
   input wire logic LINE_ERR_I,
   input wire logic [7:0] LINE_STATUS_I,
   input wire logic RX_AVAIL_I,
   input wire logic RX_NONEMPTY_I,
   input wire logic RX_CHAR_IN_I,
   input wire logic [7:0] RX_DATA_I,
   input wire logic TX_EMPTY_I,
   input wire logic TX_SHIFT_I,
   input wire logic BAUD_TICK_I,
   input wire logic [3:0] CHAR_BITS_I,
   input wire logic BAUD_CLK_I,
   input wire logic RX_READY_N_I,
   input wire logic SERIAL_RX_PIN_I,
   input wire logic CTS_N_I,
   input wire logic DSR_N_I,
   input wire logic RI_N_I,
   input wire logic DCD_N_I,
   output logic SERIAL_TX_PIN_O,
   output logic RX_SHIFT_IN_O,
   output logic DTR_N_O,
   output logic RTS_N_O,
   output logic MF_N_O,
   output logic CHANNEL_IRQ_OUT_O,
   output logic FIFO_EN_O,
   output logic RX_RD_O,
   output logic LSR_RD_O,
   output logic TX_WR_O,
   output logic [7:0] TX_DATA_O
);

   // Longest timeout is 4 chars x 16 ticks x 15 bits = 960
   if (TO_CNT_W < 10) begin : g_chk
      $error("TO_CNT_W too small for the timeout count");
   end

   typedef struct packed {
      logic [3:0] ien;
      logic fifo_en;
      logic [4:0] mlc;
      logic [1:0] psel;
      logic [3:0] iid;
      logic [3:0] mod_s1;
      logic [3:0] mod_s2;
      logic sin_s1;
      logic sin_s2;
      logic [3:0] mst;
      logic [3:0] delta;
      logic thre_ip;
      logic tx_empty_p;
      logic [TO_CNT_W-1:0] to_cnt;
      logic to_ip;
      logic [7:0] rdata;
      logic irq;
      logic dtr_n;
      logic rts_n;
      logic mf_n;
      logic serial_tx_pin;
      logic rx_in;
      logic rx_rd;
      logic lsr_rd;
      logic tx_wr;
      logic [7:0] tx_data;
   } uim_state_type;

   uim_state_type st_q;
   uim_state_type st_d;

   // Rank the gated sources into one identification code
   function automatic logic [3:0] rank(input logic ls, input logic rda,
         input logic to, input logic thre, input logic ms);
      if (ls) begin
         rank = uim_pkg::ID_LINE;
      end else if (rda) begin
         rank = uim_pkg::ID_RXDATA;
      end else if (to) begin
         rank = uim_pkg::ID_TIMEOUT;
      end else if (thre) begin
         rank = uim_pkg::ID_THRE;
      end else if (ms) begin
         rank = uim_pkg::ID_MODEM;
      end else begin
         rank = uim_pkg::ID_NONE;
      end
   endfunction : rank

   // Timeout limit in 16x ticks for the current character length
   function automatic logic [TO_CNT_W-1:0] to_limit(input logic [3:0] bits);
      to_limit = TO_CNT_W'(uim_pkg::TO_CHARS * uim_pkg::TICKS_PER_BIT
            * int'(bits));
   endfunction : to_limit

   // Gated class requests
   logic ls_on;
   logic rda_on;
   logic to_on;
   logic thre_on;
   logic ms_on;
   logic [3:0] id_now;
   logic wr_data;
   logic rd_data;
   logic rd_iid;
   logic rd_lst;
   logic rd_mst;
   logic loop;
   logic [3:0] mst_src;

   // Strobe decode and source gating
   always_comb begin
      wr_data = WR_I && (ADDR_I == uim_pkg::OFS_DATA);
      rd_data = RD_I && (ADDR_I == uim_pkg::OFS_DATA);
      rd_iid = RD_I && (ADDR_I == uim_pkg::OFS_IID);
      rd_lst = RD_I && (ADDR_I == uim_pkg::OFS_LST);
      rd_mst = RD_I && (ADDR_I == uim_pkg::OFS_MST);
      loop = st_q.mlc[uim_pkg::MLC_LOOP];
      ls_on = LINE_ERR_I && st_q.ien[uim_pkg::IEN_LINE];
      rda_on = RX_AVAIL_I && st_q.ien[uim_pkg::IEN_RX];
      to_on = st_q.to_ip && st_q.ien[uim_pkg::IEN_RX];
      thre_on = st_q.thre_ip && st_q.ien[uim_pkg::IEN_TX];
      ms_on = (|st_q.delta) && st_q.ien[uim_pkg::IEN_MODEM];
      id_now = rank(ls_on, rda_on, to_on, thre_on, ms_on);
      // Modem inputs: complemented pins, or control bits in loopback
      if (loop) begin
         mst_src = {st_q.mlc[uim_pkg::MLC_OUT2], st_q.mlc[uim_pkg::MLC_OUT1],
               st_q.mlc[uim_pkg::MLC_DTR], st_q.mlc[uim_pkg::MLC_RTS]};
      end else begin
         mst_src = ~st_q.mod_s2;
      end
   end

   // Next state
   always_comb begin
      st_d = st_q;
      st_d.rx_rd = rd_data;
      st_d.lsr_rd = rd_lst;
      st_d.tx_wr = wr_data;
      // Synchronisers for pins from outside the clock domain
      st_d.mod_s1 = {DCD_N_I, RI_N_I, DSR_N_I, CTS_N_I};
      st_d.mod_s2 = st_q.mod_s1;
      st_d.sin_s1 = SERIAL_RX_PIN_I;
      st_d.sin_s2 = st_q.sin_s1;
      // Register writes
      if (WR_I) begin
         if (ADDR_I == uim_pkg::OFS_DATA) begin
            st_d.tx_data = WDATA_I;
         end else if (ADDR_I == uim_pkg::OFS_IEN) begin
            st_d.ien = WDATA_I[3:0];
         end else if (ADDR_I == uim_pkg::OFS_IID) begin
            st_d.fifo_en = WDATA_I[uim_pkg::FCR_EN];
         end else if (ADDR_I == uim_pkg::OFS_PSEL) begin
            st_d.psel = WDATA_I[1:0];
         end else if (ADDR_I == uim_pkg::OFS_MLC) begin
            st_d.mlc = WDATA_I[4:0];
         end
      end
      // Identification frozen while it is being read
      if (!rd_iid) begin
         st_d.iid = id_now;
      end
      // Modem status: deltas set on change (ring only on its trailing edge), read clears, set wins
      st_d.mst = mst_src;
      if (rd_mst) begin
         st_d.delta = 4'h0;
      end
      st_d.delta[0] = st_d.delta[0] | (mst_src[0] ^ st_q.mst[0]);
      st_d.delta[1] = st_d.delta[1] | (mst_src[1] ^ st_q.mst[1]);
      st_d.delta[2] = st_d.delta[2] | (st_q.mst[2] & ~mst_src[2]);
      st_d.delta[3] = st_d.delta[3] | (mst_src[3] ^ st_q.mst[3]);
      // Tx empty: cleared by write or ident read naming it
      st_d.tx_empty_p = TX_EMPTY_I;
      if (wr_data || (rd_iid && st_q.iid == uim_pkg::ID_THRE)) begin
         st_d.thre_ip = 1'b0;
      end
      if (TX_EMPTY_I && !st_q.tx_empty_p) begin
         st_d.thre_ip = 1'b1;
      end
      // Character timeout, restarted by any Rx FIFO activity
      if (!st_q.fifo_en || !RX_NONEMPTY_I || RX_CHAR_IN_I || rd_data) begin
         st_d.to_cnt = '0;
      end else if (BAUD_TICK_I && st_q.to_cnt != to_limit(CHAR_BITS_I)) begin
         st_d.to_cnt = st_q.to_cnt + TO_CNT_W'(1);
      end
      if (rd_data || !st_q.fifo_en) begin
         st_d.to_ip = 1'b0;
      end else if (RX_NONEMPTY_I
            && st_q.to_cnt == to_limit(CHAR_BITS_I)) begin
         st_d.to_ip = 1'b1;
      end
      // Read data, one cycle after the strobe
      st_d.rdata = 8'h00;
      if (RD_I) begin
         if (ADDR_I == uim_pkg::OFS_DATA) begin
            st_d.rdata = RX_DATA_I;
         end else if (ADDR_I == uim_pkg::OFS_IEN) begin
            st_d.rdata = {4'h0, st_q.ien};
         end else if (ADDR_I == uim_pkg::OFS_IID) begin
            st_d.rdata = {{2{st_q.fifo_en}}, 2'b00,
                  st_q.iid[3] & st_q.fifo_en, st_q.iid[2:0]};
         end else if (ADDR_I == uim_pkg::OFS_PSEL) begin
            st_d.rdata = {6'h00, st_q.psel};
         end else if (ADDR_I == uim_pkg::OFS_MLC) begin
            st_d.rdata = {3'h0, st_q.mlc};
         end else if (ADDR_I == uim_pkg::OFS_LST) begin
            st_d.rdata = LINE_STATUS_I;
         end else if (ADDR_I == uim_pkg::OFS_MST) begin
            st_d.rdata = {st_q.mst, st_q.delta};
         end
      end
      // Interrupt output follows any enabled pending source
      st_d.irq = (id_now != uim_pkg::ID_NONE);
      // Output pins: inverted controls, forced high in loopback; baud clock and rx ready on the shared pin are not
      st_d.dtr_n = loop | ~st_q.mlc[uim_pkg::MLC_DTR];
      st_d.rts_n = loop | ~st_q.mlc[uim_pkg::MLC_RTS];
      if (st_q.psel == uim_pkg::PSEL_OUT2) begin
         st_d.mf_n = loop | ~st_q.mlc[uim_pkg::MLC_OUT2];
      end else if (st_q.psel == uim_pkg::PSEL_BAUD) begin
         st_d.mf_n = BAUD_CLK_I;
      end else if (st_q.psel == uim_pkg::PSEL_RECEIVE_READY_DMA) begin
         st_d.mf_n = RX_READY_N_I;
      end else begin
         st_d.mf_n = 1'b1;  // Reserved code drives high
      end
      // Serial path: mark on the line, shifter looped inside
      st_d.serial_tx_pin = loop | TX_SHIFT_I;
      st_d.rx_in = loop ? TX_SHIFT_I : st_q.sin_s2;
   end

   // State register; reset leaves pins inactive and OUT2 selected
   always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         st_q <= '0;
         st_q.ien <= uim_pkg::IEN_RST;
         st_q.mlc <= uim_pkg::MLC_RST;
         st_q.psel <= uim_pkg::PSEL_RST;
         st_q.iid <= uim_pkg::ID_NONE;
         st_q.mod_s1 <= 4'hF;
         st_q.mod_s2 <= 4'hF;
         st_q.sin_s1 <= 1'b1;
         st_q.sin_s2 <= 1'b1;
         st_q.dtr_n <= 1'b1;
         st_q.rts_n <= 1'b1;
         st_q.mf_n <= 1'b1;
         st_q.serial_tx_pin <= 1'b1;
         st_q.rx_in <= 1'b1;
      end else begin
         st_q <= st_d;
      end
   end

   // Port drive, all from flip-flops
   assign RDATA_O = st_q.rdata;
   assign SERIAL_TX_PIN_O = st_q.serial_tx_pin;
   assign RX_SHIFT_IN_O = st_q.rx_in;
   assign DTR_N_O = st_q.dtr_n;
   assign RTS_N_O = st_q.rts_n;
   assign MF_N_O = st_q.mf_n;
   assign CHANNEL_IRQ_OUT_O = st_q.irq;
   assign FIFO_EN_O = st_q.fifo_en;
   assign RX_RD_O = st_q.rx_rd;
   assign LSR_RD_O = st_q.lsr_rd;
   assign TX_WR_O = st_q.tx_wr;
   assign TX_DATA_O = st_q.tx_data;

   // Checks on the block's own state registers and outputs
   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (SYS_RST_I);

   sequence s_iid_read;
      RD_I && ADDR_I == uim_pkg::OFS_IID;
   endsequence

   sequence s_line_only;
      LINE_ERR_I && st_q.ien[uim_pkg::IEN_LINE] && !RD_I;
   endsequence

   a_iid_frozen: assert property (s_iid_read |=> st_q.iid == $past(st_q.iid))
      else $error("Identification changed during its read");

   a_line_first: assert property (s_line_only ##1 s_line_only
         |-> st_q.iid == uim_pkg::ID_LINE)
      else $error("Line status not ranked highest");

   a_iid_upper: assert property (s_iid_read |=> RDATA_O[5:4] == 2'b00
         && RDATA_O[7:6] == {2{$past(st_q.fifo_en)}})
      else $error("Identification upper bits wrong");

   a_irq_pending: assert property ((s_iid_read
         and (st_q.iid == uim_pkg::ID_NONE && !st_d.irq))
         |=> RDATA_O[0] && !CHANNEL_IRQ_OUT_O)
      else $error("Irq and pending bit disagree");

   // Both registers load from one ranking, so they agree except in the cycle after an ident read
   a_irq_ident: assert property (!(RD_I && ADDR_I == uim_pkg::OFS_IID)
         |=> CHANNEL_IRQ_OUT_O == (st_q.iid != uim_pkg::ID_NONE))
      else $error("Irq and identification disagree");

   a_ien_upper: assert property (RD_I && ADDR_I == uim_pkg::OFS_IEN
         |=> RDATA_O[7:4] == 4'h0)
      else $error("Enable upper bits not zero");

   a_loop_pins: assert property (st_q.mlc[uim_pkg::MLC_LOOP]
         |=> DTR_N_O && RTS_N_O && SERIAL_TX_PIN_O)
      else $error("Loopback pins not inactive");

   a_dtr_invert: assert property (!st_q.mlc[uim_pkg::MLC_LOOP]
         |=> DTR_N_O == !$past(st_q.mlc[uim_pkg::MLC_DTR]))
      else $error("Terminal ready pin not inverted");

   a_thre_clear: assert property (WR_I && ADDR_I == uim_pkg::OFS_DATA
         && !(TX_EMPTY_I && !st_q.tx_empty_p) |=> !st_q.thre_ip)
      else $error("Tx empty not cleared by write");

   a_timeout_nofifo: assert property (!st_q.fifo_en |=> !st_q.to_ip)
      else $error("Timeout pending outside FIFO mode");

   a_disabled_hidden: assert property (st_q.ien == 4'h0 && !RD_I
         ##1 st_q.ien == 4'h0 |-> st_q.iid == uim_pkg::ID_NONE)
      else $error("Disabled class shown");

endmodule : uim_channel

// ==== hdl/uim_pkg.sv ====
// Purpose: Shared constants for the channel interrupt and modem control block
// Assumes: One channel, 8-bit register port, 3-bit register address
// Notes: Offsets follow the classic serial controller layout
package uim_pkg;
   // Register offsets
   localparam logic [2:0] OFS_DATA = 3'h0;  // Rx buffer read, Tx holding write
   localparam logic [2:0] OFS_IEN = 3'h1;   // Interrupt enable
   localparam logic [2:0] OFS_IID = 3'h2;   // Ident read, FIFO control write
   localparam logic [2:0] OFS_PSEL = 3'h3;  // Multi-function pin select
   localparam logic [2:0] OFS_MLC = 3'h4;   // Modem line control
   localparam logic [2:0] OFS_LST = 3'h5;   // Line status
   localparam logic [2:0] OFS_MST = 3'h6;   // Modem status
   // Identification codes, low nibble
   localparam logic [3:0] ID_NONE = 4'h1;
   localparam logic [3:0] ID_LINE = 4'h6;
   localparam logic [3:0] ID_RXDATA = 4'h4;
   localparam logic [3:0] ID_TIMEOUT = 4'hC;
   localparam logic [3:0] ID_THRE = 4'h2;
   localparam logic [3:0] ID_MODEM = 4'h0;
   // Enable bit positions
   localparam int IEN_RX = 0;
   localparam int IEN_TX = 1;
   localparam int IEN_LINE = 2;
   localparam int IEN_MODEM = 3;
   // Modem line control bit positions
   localparam int MLC_DTR = 0;
   localparam int MLC_RTS = 1;
   localparam int MLC_OUT1 = 2;
   localparam int MLC_OUT2 = 3;
   localparam int MLC_LOOP = 4;
   // FIFO control bit position
   localparam int FCR_EN = 0;
   // Multi-function pin selections
   localparam logic [1:0] PSEL_OUT2 = 2'h0;
   localparam logic [1:0] PSEL_BAUD = 2'h1;
   localparam logic [1:0] PSEL_RECEIVE_READY_DMA = 2'h2;
   // Timeout: character times and 16x ticks per bit
   localparam int TO_CHARS = 4;
   localparam int TICKS_PER_BIT = 16;
   // Reset values
   localparam logic [3:0] IEN_RST = 4'h0;
   localparam logic [4:0] MLC_RST = 5'h00;
   localparam logic [1:0] PSEL_RST = 2'h0;
endpackage : uim_pkg

// ==== testbench/uim_channel_test.sv ====
// Purpose: Register level test of interrupt ranking and modem control
// Assumes: Modem partner echoes RTS to CTS and DTR to DSR
// Notes: Baud tick every other cycle keeps the timeout run short
`timescale 1ns/1ps
module uim_channel_test;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [2:0] addr = 3'h0;
   logic [7:0] wdata = 8'h00;
   logic wr_s = 1'b0;
   logic rd_s = 1'b0;
   logic [7:0] rdata;
   logic line_err = 1'b0;
   logic rx_avail = 1'b0;
   logic rx_nonempty = 1'b0;
   logic tx_empty = 1'b0;
   logic tx_shift = 1'b1;
   logic tick = 1'b0;
   logic serial_rx = 1'b1;
   logic rx_char_in = 1'b0;
   logic rx_ready_n = 1'b1;
   logic ring_n = 1'b1;
   logic carrier_n = 1'b1;
   logic rx_rd, lsr_rd, tx_wr;
   int n_rx_rd = 0;
   int n_lsr_rd = 0;
   int n_tx_wr = 0;
   logic cts_n, dsr_n, ri_n, dcd_n, tx_pin, rx_in, dtr_n, rts_n, mf_n;
   logic irq, fifo_en;
   logic [7:0] tx_data;
   int num_errors = 0;
   int total_checks = 0;
   // Clock and a free baud tick
   always #10 clk = ~clk;
   always @(posedge clk) tick <= ~tick;
   uim_channel #(.TO_CNT_W(12)) DUT (.CLK_I(clk), .SYS_RST_I(rst),
      .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr_s), .RD_I(rd_s),
      .RDATA_O(rdata), .LINE_ERR_I(line_err), .LINE_STATUS_I(8'h9E),
      .RX_AVAIL_I(rx_avail), .RX_NONEMPTY_I(rx_nonempty),
      .RX_CHAR_IN_I(rx_char_in), .RX_DATA_I(8'h5A), .TX_EMPTY_I(tx_empty),
      .TX_SHIFT_I(tx_shift), .BAUD_TICK_I(tick), .CHAR_BITS_I(4'hA),
      .BAUD_CLK_I(tick), .RX_READY_N_I(rx_ready_n),
      .SERIAL_RX_PIN_I(serial_rx),
      .CTS_N_I(cts_n), .DSR_N_I(dsr_n), .RI_N_I(ri_n), .DCD_N_I(dcd_n),
      .SERIAL_TX_PIN_O(tx_pin), .RX_SHIFT_IN_O(rx_in), .DTR_N_O(dtr_n),
      .RTS_N_O(rts_n), .MF_N_O(mf_n), .CHANNEL_IRQ_OUT_O(irq),
      .FIFO_EN_O(fifo_en), .RX_RD_O(rx_rd), .LSR_RD_O(lsr_rd),
      .TX_WR_O(tx_wr),
      .TX_DATA_O(tx_data));
   uim_modem_model #(.DLY(3)) modem (.clk_i(clk), .dtr_n_i(dtr_n),
      .rts_n_i(rts_n), .ring_n_i(ring_n), .carrier_n_i(carrier_n),
      .cts_n_o(cts_n), .dsr_n_o(dsr_n), .ri_n_o(ri_n), .dcd_n_o(dcd_n));
   // Pulses towards the data path; a stuck pulse counts more than once
   always @(posedge clk) begin
      if (rx_rd === 1'b1) n_rx_rd++;
      if (lsr_rd === 1'b1) n_lsr_rd++;
      if (tx_wr === 1'b1) n_tx_wr++;
   end
   // Single compare point, counts every check
   task chk(input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("Error at %0t: got %h want %h", $time, seen, exp);
      end
   endtask : chk
   task cyc(input int n);
      repeat (n) @(posedge clk);
   endtask : cyc
   task wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr_s <= 1'b1;
      @(posedge clk);
      wr_s <= 1'b0;
   endtask : wr
   // Read data stands only in the cycle after the strobe; taken at its end
   task rd(input logic [2:0] a, output logic [7:0] v);
      @(posedge clk);
      addr <= a;
      rd_s <= 1'b1;
      @(posedge clk);
      rd_s <= 1'b0;
      @(posedge clk);
      v = rdata;
   endtask : rd
   task rdc(input logic [2:0] a, input logic [7:0] exp);
      logic [7:0] v;
      rd(a, v);
      chk(v, exp);
   endtask : rdc
   task test_done;
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : test_done
   // Main sequence
   initial begin
      logic [7:0] v;
      int i;
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      rdc(uim_pkg::OFS_IID, 8'h01);
      rdc(uim_pkg::OFS_IEN, 8'h00);
      chk({5'h0, dtr_n, rts_n, mf_n}, 8'h07);
      wr(uim_pkg::OFS_IEN, 8'hF8);
      rdc(uim_pkg::OFS_IEN, 8'h08);
      // Raise RTS, modem echoes CTS, modem class reported
      wr(uim_pkg::OFS_MLC, 8'hE2);
      rdc(uim_pkg::OFS_MLC, 8'h02);
      cyc(1);
      chk({5'h0, dtr_n, rts_n, mf_n}, 8'h05);
      cyc(12);
      chk({7'h0, irq}, 8'h01);
      rdc(uim_pkg::OFS_IID, 8'h00);
      rdc(uim_pkg::OFS_MST, 8'h11);
      rdc(uim_pkg::OFS_IID, 8'h01);
      // Modem class disabled while a delta is pending
      wr(uim_pkg::OFS_IEN, 8'h06);
      wr(uim_pkg::OFS_MLC, 8'h08);
      cyc(12);
      chk({5'h0, dtr_n, rts_n, mf_n}, 8'h06);
      rdc(uim_pkg::OFS_IID, 8'h01);
      rdc(uim_pkg::OFS_MST, 8'h01);
      // Tx empty: cleared by ident read, then by data write
      tx_empty <= 1'b1;
      cyc(3);
      rdc(uim_pkg::OFS_IID, 8'h02);
      rdc(uim_pkg::OFS_IID, 8'h01);
      tx_empty <= 1'b0;
      cyc(2);
      tx_empty <= 1'b1;
      cyc(3);
      chk({7'h0, irq}, 8'h01);
      wr(uim_pkg::OFS_DATA, 8'h33);
      tx_empty <= 1'b0;
      cyc(2);
      chk(tx_data, 8'h33);
      rdc(uim_pkg::OFS_IID, 8'h01);
      chk({7'h0, irq}, 8'h00);
      // Line error outranks rx data; line enable gates it
      line_err <= 1'b1;
      rx_avail <= 1'b1;
      wr(uim_pkg::OFS_IEN, 8'h03);
      cyc(2);
      rdc(uim_pkg::OFS_IID, 8'h04);
      wr(uim_pkg::OFS_IEN, 8'h07);
      cyc(2);
      rdc(uim_pkg::OFS_IID, 8'h06);
      line_err <= 1'b0;
      rdc(uim_pkg::OFS_LST, 8'h9E);
      cyc(2);
      rdc(uim_pkg::OFS_IID, 8'h04);
      rx_avail <= 1'b0;
      cyc(2);
      rdc(uim_pkg::OFS_IID, 8'h01);
      // FIFO mode and the character timeout
      wr(uim_pkg::OFS_IID, 8'h01);
      cyc(2);
      chk({7'h0, fifo_en}, 8'h01);
      rdc(uim_pkg::OFS_IID, 8'hC1);
      rx_nonempty <= 1'b1;
      // A new character part way restarts the four character wait
      cyc(1000);
      rx_char_in <= 1'b1;
      cyc(1);
      rx_char_in <= 1'b0;
      cyc(1000);
      chk({7'h0, irq}, 8'h00);
      for (i = 0; i < 3000 && irq !== 1'b1; i++) @(posedge clk);
      chk({7'h0, irq}, 8'h01);
      rdc(uim_pkg::OFS_IID, 8'hCC);
      rdc(uim_pkg::OFS_DATA, 8'h5A);
      cyc(2);
      rdc(uim_pkg::OFS_IID, 8'hC1);
      rx_nonempty <= 1'b0;
      wr(uim_pkg::OFS_IID, 8'h00);
      cyc(2);
      rdc(uim_pkg::OFS_IID, 8'h01);
      // Shared pin: rx ready, baud clock, reserved, then OUT2 again
      wr(uim_pkg::OFS_PSEL, 8'h02);
      cyc(2);
      chk({7'h0, mf_n}, 8'h01);
      rx_ready_n <= 1'b0;
      cyc(3);
      chk({7'h0, mf_n}, 8'h00);
      rdc(uim_pkg::OFS_PSEL, 8'h02);
      wr(uim_pkg::OFS_PSEL, 8'h01);
      cyc(2);
      chk({7'h0, mf_n}, {7'h0, ~tick});
      wr(uim_pkg::OFS_PSEL, 8'h03);
      cyc(2);
      chk({7'h0, mf_n}, 8'h01);
      wr(uim_pkg::OFS_PSEL, 8'h00);
      cyc(2);
      chk({7'h0, mf_n}, 8'h00);
      // Serial input passes through outside loopback
      serial_rx <= 1'b0;
      cyc(4);
      chk({6'h0, tx_pin, rx_in}, 8'h02);
      // Local loopback of data and modem lines
      wr(uim_pkg::OFS_IEN, 8'h08);
      wr(uim_pkg::OFS_MLC, 8'h1F);
      tx_shift <= 1'b0;
      serial_rx <= 1'b1;
      cyc(12);
      chk({5'h0, dtr_n, rts_n, mf_n}, 8'h07);
      chk({6'h0, tx_pin, rx_in}, 8'h02);
      rdc(uim_pkg::OFS_IID, 8'h00);
      rd(uim_pkg::OFS_MST, v);
      chk({4'h0, v[7:4]}, 8'h0F);
      rdc(uim_pkg::OFS_IID, 8'h01);
      wr(uim_pkg::OFS_MLC, 8'h1B);
      cyc(8);
      rdc(uim_pkg::OFS_MLC, 8'h1B);
      rdc(uim_pkg::OFS_IID, 8'h00);
      rdc(uim_pkg::OFS_MST, 8'hB4);
      wr(uim_pkg::OFS_MLC, 8'h00);
      cyc(4);
      chk({6'h0, tx_pin, rx_in}, 8'h01);
      rdc(uim_pkg::OFS_MST, 8'h0B);
      // Ring counts only on its trailing edge; carrier on any change
      ring_n <= 1'b0;
      cyc(6);
      rdc(uim_pkg::OFS_MST, 8'h40);
      ring_n <= 1'b1;
      carrier_n <= 1'b0;
      cyc(6);
      rdc(uim_pkg::OFS_IID, 8'h00);
      rdc(uim_pkg::OFS_MST, 8'h8C);
      // Each strobe towards the data path pulsed once per access
      chk(8'(n_rx_rd), 8'h01);
      chk(8'(n_lsr_rd), 8'h01);
      chk(8'(n_tx_wr), 8'h01);
      test_done;
   end
endmodule : uim_channel_test

// ==== testbench/uim_modem_model.sv ====
// Purpose: Modem partner echoing handshake outputs back as its inputs
// Assumes: All modem lines are low active
// Notes: DLY sets how slowly the modem answers; ring and carrier from bench
`timescale 1ns/1ps
module uim_modem_model #(
   parameter int DLY = 3
) (
   input wire logic clk_i,
   input wire logic dtr_n_i,
   input wire logic rts_n_i,
   input wire logic ring_n_i,
   input wire logic carrier_n_i,
   output logic cts_n_o,
   output logic dsr_n_o,
   output logic ri_n_o,
   output logic dcd_n_o
);
   logic [DLY-1:0] dtr_sr = '1;
   logic [DLY-1:0] rts_sr = '1;
   // Null-modem echo, lagged so the answer is not instant
   always @(posedge clk_i) begin
      dtr_sr <= {dtr_sr[DLY-2:0], dtr_n_i};
      rts_sr <= {rts_sr[DLY-2:0], rts_n_i};
   end
   // Ring and carrier are the bench's to wiggle
   assign dsr_n_o = dtr_sr[DLY-1];
   assign cts_n_o = rts_sr[DLY-1];
   assign ri_n_o = ring_n_i;
   assign dcd_n_o = carrier_n_i;
endmodule : uim_modem_model
